// ===== shared/lcs_consts.svh
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH

// Wishbone register byte offsets.
`define LCS_REG_CTRL      8'h00
`define LCS_REG_STATUS    8'h04
`define LCS_REG_SELECT    8'h08

// Control register field positions.
`define LCS_CTRL_SA_BIT   0
`define LCS_CTRL_MODE_LO  1
`define LCS_CTRL_MODE_HI  2
`define LCS_CTRL_BP_EN    3

// Select register field positions.
`define LCS_SEL_SUB_LO    0
`define LCS_SEL_SUB_HI    2
`define LCS_SEL_SA_BIT    3

// Reset values.
`define LCS_CTRL_RESET    4'h0
`define LCS_SEL_RESET     4'h0

// Display clock ticks held in one backplane phase.
`define LCS_PHASE_TICKS   8'h08

`endif

// ===== shared/lcs_pkg.sv
package lcs_pkg;

  // Multiplex drive mode: static, 1:2, 1:3, 1:4.
  typedef enum logic [1:0] {
    LCS_MODE_STATIC,
    LCS_MODE_DUPLEX,
    LCS_MODE_TRIPLEX,
    LCS_MODE_QUAD
  } lcs_mode_t;

  // Open-drain sync pin drive: output level and output enable.
  typedef struct packed {
    logic out;
    logic oe;
  } lcs_sync_drv_t;

  // Command-stream address selection and data strobe.
  typedef struct packed {
    logic [2:0] sub;
    logic       sa;
    logic       data_vld;
  } lcs_cmd_t;

endpackage : lcs_pkg

// ===== core/lcs_phase_gen.sv
`include "lcs_consts.svh"

// Backplane phase sequencer stepped by display clock ticks.
module lcs_phase_gen #(
  parameter logic [7:0] PHASE_TICKS = `LCS_PHASE_TICKS
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Control
  input  wire logic       tick_i,
  input  wire logic [1:0] last_phase_i,
  input  wire logic       realign_i,
  // Status
  output logic [1:0]      phase_o,
  output logic            phase_start_o
);

  logic [7:0] tick_cnt;

  // Realignment places the sequence one tick into the last phase, the point where the asserting unit is.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tick_cnt      <= 8'h00;
      phase_o       <= 2'h0;
      phase_start_o <= 1'b0;
    end else if (realign_i) begin
      tick_cnt      <= 8'h01;
      phase_o       <= last_phase_i;
      phase_start_o <= 1'b0;
    end else if (tick_i) begin
      if (tick_cnt == PHASE_TICKS - 8'h01) begin
        tick_cnt      <= 8'h00;
        phase_o       <= (phase_o >= last_phase_i) ? 2'h0 : phase_o + 2'h1;
        phase_start_o <= 1'b1;
      end else begin
        tick_cnt      <= tick_cnt + 8'h01;
        phase_start_o <= 1'b0;
      end
    end else begin
      phase_start_o <= 1'b0;
    end
  end

endmodule : lcs_phase_gen

// ===== core/lcs_cascade_sync.sv
`include "lcs_consts.svh"

// Notes on behaviour
// (R01) Up to sixteen units told apart by three strap pins plus one select bit.
// (R02) Unit index is select bit on top, strap pins below.
// (R03) Reset starts every unit at phase zero so the cascade begins aligned.
// (R04) Sync pin is open drain: only pulls low, otherwise released to pull-up.
// (R05) Pull sync during the last active backplane phase; sample it otherwise.
// (R06) Seeing sync pulled by another unit while out of step realigns our phase.
// (R07) Controller expects lost alignment when mixing select bits in multiplex mode.
// (R08) Exactly one unit supplies the display clock; the rest take it.
// (R09) With an external clock all units take it; keep skew equal.
// (R10) Only one unit's backplanes drive the display when synchronized.
// (R11) Display data accepted only while command address matches our address.
module lcs_cascade_sync
#(
  parameter logic [7:0] PHASE_TICKS = `LCS_PHASE_TICKS
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  // Wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [31:0]   wb_dat_i,
  input  wire logic [3:0]    wb_sel_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  // Straps
  input  wire logic          subaddr_pin_bit0_i,
  input  wire logic          subaddr_pin_bit1_i,
  input  wire logic          subaddr_pin_bit2_i,
  // Display clock tick, from the master unit or external source
  input  wire logic          disp_clk_tick_i,
  // Serial command address and data strobe
  input  wire lcs_pkg::lcs_cmd_t cmd_i,
  output logic               data_accept_o,
  // Cascade sync pin
  input  wire logic          sync_n_i,
  output lcs_pkg::lcs_sync_drv_t sync_o,
  // Backplane phase
  output logic [1:0]         bp_phase_o,
  output logic               bp_drive_en_o
);

  import lcs_pkg::*;

  logic [3:0] ctrl;
  logic [3:0] sel_reg;
  logic [2:0] subaddr;
  logic [3:0] dev_index;
  logic [3:0] cmd_index;
  logic [1:0] last_phase;
  logic [1:0] phase;
  logic       phase_start;
  logic       realign;
  logic       sync_prev;
  logic       out_of_step;
  logic       wb_req;
  logic       addr_match;

  lcs_mode_t  mode;

  assign mode       = lcs_mode_t'(ctrl[`LCS_CTRL_MODE_HI:`LCS_CTRL_MODE_LO]);
  assign last_phase = mode;
  assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Straps are sampled every cycle so a board change is picked up without a reset.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      subaddr <= 3'h0;
    end else begin
      subaddr <= {subaddr_pin_bit2_i, subaddr_pin_bit1_i, subaddr_pin_bit0_i}; // [R01]
    end
  end

  assign dev_index = {ctrl[`LCS_CTRL_SA_BIT], subaddr}; // [R02]
  assign cmd_index = {cmd_i.sa, cmd_i.sub};
  assign addr_match = (dev_index == cmd_index);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      data_accept_o <= 1'b0;
    end else begin
      data_accept_o <= cmd_i.data_vld & addr_match; // [R11]
    end
  end

  // Register writes land on the acknowledging edge.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl    <= `LCS_CTRL_RESET;
      sel_reg <= `LCS_SEL_RESET;
    end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == `LCS_REG_CTRL) begin
        ctrl <= wb_dat_i[3:0];
      end else if (wb_adr_i == `LCS_REG_SELECT) begin
        sel_reg <= wb_dat_i[3:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == `LCS_REG_CTRL) begin
          wb_dat_o <= {28'h000_0000, ctrl};
        end else if (wb_adr_i == `LCS_REG_STATUS) begin
          wb_dat_o <= {24'h00_0000, 1'b0, out_of_step, phase, dev_index};
        end else if (wb_adr_i == `LCS_REG_SELECT) begin
          wb_dat_o <= {28'h000_0000, sel_reg};
        end else begin
          wb_dat_o <= 32'h0000_0000;
        end
      end
    end
  end

  // A falling sync edge seen outside our own last phase means another unit is ahead of us.
  assign out_of_step = (phase != last_phase);
  assign realign     = sync_prev & ~sync_n_i & out_of_step & ~sync_o.oe; // [R06]

  // Starting at the released level keeps a false falling edge from following reset.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync_prev <= 1'b1;
    end else begin
      sync_prev <= sync_n_i;
    end
  end

  lcs_phase_gen #(
    .PHASE_TICKS (PHASE_TICKS)
  ) u_phase (
    .clk_i         (clk_i),
    .sys_rst_i     (sys_rst_i), // [R03]
    .tick_i        (disp_clk_tick_i),
    .last_phase_i  (last_phase),
    .realign_i     (realign),
    .phase_o       (phase),
    .phase_start_o (phase_start)
  );

  // Pin only ever driven low; the released line is pulled high outside.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync_o.out <= 1'b0;
      sync_o.oe  <= 1'b0;
    end else begin
      sync_o.out <= 1'b0; // [R04]
      sync_o.oe  <= (phase == last_phase) && !realign; // [R05]
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bp_phase_o    <= 2'h0;
      bp_drive_en_o <= 1'b0;
    end else begin
      bp_phase_o    <= phase;
      bp_drive_en_o <= ctrl[`LCS_CTRL_BP_EN]; // [R10]
    end
  end

  a_sync_pull_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R04]
    sync_o.out == 1'b0) else $error("sync pin driven high");

  // The reset term in the antecedent stops the release edge itself from starting a check.
  a_sync_last_phase: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R05]
    !sys_rst_i && (phase == last_phase) && !realign |=> sync_o.oe)
    else $error("sync not pulled in last phase");

  sequence s_last_onset;
    phase_start && (phase == last_phase);
  endsequence

  a_sync_onset: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R05]
    s_last_onset |=> sync_o.oe) else $error("sync not pulled at last phase onset");

  a_sync_released: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R05]
    (phase != last_phase) |=> !sync_o.oe) else $error("sync pulled outside last phase");

  sequence s_foreign_edge;
    sync_prev && !sync_n_i && (phase != last_phase) && !sync_o.oe;
  endsequence

  a_realign_phase: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R06]
    s_foreign_edge |=> (phase == $past(last_phase))) else $error("no realign on sync");

  a_realign_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R06]
    realign |=> !sync_o.oe) else $error("sync pulled in realign cycle");

  a_accept_match: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R11]
    data_accept_o |-> $past(cmd_i.data_vld) && ($past(cmd_index) == $past(dev_index)))
    else $error("data accepted without address match");

  a_accept_taken: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R11]
    cmd_i.data_vld && addr_match |=> data_accept_o) else $error("matching data refused");

  a_accept_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R11]
    !cmd_i.data_vld |=> !data_accept_o) else $error("data accepted without strobe");

  a_index_strap: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R01]
    !sys_rst_i |=> dev_index[2:0] == $past({subaddr_pin_bit2_i, subaddr_pin_bit1_i, subaddr_pin_bit0_i}))
    else $error("strap not in index");

  a_index_msb: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R02]
    dev_index[3] == ctrl[`LCS_CTRL_SA_BIT]) else $error("select bit not index msb");

  a_status_index: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R02]
    wb_req && !wb_we_i && (wb_adr_i == `LCS_REG_STATUS) |=> wb_dat_o[3:0] == $past(dev_index))
    else $error("status read lost unit index");

  a_reset_phase: assert property (@(posedge clk_i) // [R03]
    sys_rst_i |=> (phase == 2'h0) && !sync_o.oe) else $error("reset phase not zero");

  a_wb_ack_once: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

endmodule : lcs_cascade_sync

// ===== tb/lcs_peer.sv
// Stands in for the clock-source unit and for one other unit on the sync line.
module lcs_peer (
  // Clock
  input  wire logic clk_i,
  // Request from the bench to pull sync
  input  wire logic pull_i,
  // Display clock tick and open-drain pull
  output logic      tick_o,
  output logic      pull_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic cnt = 1'b0;

  // One tick every second cycle keeps each phase short, so runs stay brief.
  always @(posedge clk_i) begin
    cnt <= ~cnt;
  end

  assign tick_o = cnt;
  // The peer only ever pulls; the pull-up in the bench restores the line.
  assign pull_o = pull_i;
endmodule : lcs_peer

// ===== tb/lcs_cascade_sync_tb.sv
`include "lcs_consts.svh"

module lcs_cascade_sync_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lcs_pkg::*;

  logic          clk_i     = 1'b0;
  logic          sys_rst_i = 1'b1;
  logic          cyc       = 1'b0;
  logic          stb       = 1'b0;
  logic          we        = 1'b0;
  logic          pull      = 1'b0;
  logic [7:0]    adr       = 8'h00;
  logic [31:0]   dat       = 32'h0000_0000;
  logic [31:0]   rd;
  logic [31:0]   dat_o;
  logic [2:0]    sub       = 3'h0;
  logic [3:0]    sel       = 4'h0;
  lcs_cmd_t      cmd       = '0;
  lcs_sync_drv_t sync;
  logic          ack, acc, tick, pull_o, sync_n, bp_en;
  logic [1:0]    ph;
  int            fail_count  = 0;
  int            comparisons = 0;
  int            cycles      = 0;
  int            n;

  // Open-drain line with pull-up: low while either party pulls.
  assign sync_n = ~(sync.oe | pull_o);
  always #5 clk_i = ~clk_i;

  lcs_cascade_sync #(.PHASE_TICKS(8'h02)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .subaddr_pin_bit0_i(sub[0]), .subaddr_pin_bit1_i(sub[1]), .subaddr_pin_bit2_i(sub[2]),
    .disp_clk_tick_i(tick), .cmd_i(cmd), .data_accept_o(acc), .sync_n_i(sync_n),
    .sync_o(sync), .bp_phase_o(ph), .bp_drive_en_o(bp_en)
  );

  lcs_peer peer (.clk_i(clk_i), .pull_i(pull), .tick_o(tick), .pull_o(pull_o));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= 4'hF;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd  = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic end_sim();
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // Generous ceiling: the whole sequence needs well under a thousand cycles.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    chk(ph, 32'h0000_0000);
    chk(sync.oe, 32'h0000_0000);
    wb(1'b0, `LCS_REG_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wb(1'b1, 8'h0C, 32'h0000_000F);
    wb(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wb(1'b1, `LCS_REG_SELECT, 32'h0000_000A);
    wb(1'b0, `LCS_REG_SELECT, 32'h0000_0000);
    chk(rd, 32'h0000_000A);
    // Every unit index, every drive mode along the way.
    for (int i = 0; i < 16; i++) begin
      sub <= i[2:0];
      wb(1'b1, `LCS_REG_CTRL, {28'h000_0000, 1'b0, i[1:0], i[3]});
      wb(1'b0, `LCS_REG_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_000F, i);
    end
    sub <= 3'h5;
    wb(1'b1, `LCS_REG_CTRL, 32'h0000_0001);
    for (int s = 0; s < 2; s++) begin
      cmd <= {3'h5, s[0], 1'b1};
      @(posedge clk_i);
      cmd <= '0;
      @(posedge clk_i);
      chk(acc, s);
    end
    wb(1'b1, `LCS_REG_CTRL, 32'h0000_000E);
    repeat (3) @(posedge clk_i);
    chk(bp_en, 32'h0000_0001);
    do @(posedge clk_i); while (ph !== 2'h3);
    @(posedge clk_i);
    chk(sync.oe, 32'h0000_0001);
    chk(sync.out, 32'h0000_0000);
    do @(posedge clk_i); while (ph !== 2'h1);
    chk(sync.oe, 32'h0000_0000);
    pull <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ph !== 2'h3 && n < 4);
    pull <= 1'b0;
    chk(ph, 32'h0000_0003);
    chk(n < 4, 32'h0000_0001);
    end_sim();
  end
endmodule : lcs_cascade_sync_tb
